/* hdl/eiec_cfg.svh */
`ifndef EIEC_CFG_SVH
`define EIEC_CFG_SVH

// Line counts and pin multiplexer geometry.
`define EIEC_NUM_LINES 23
`define EIEC_NUM_PIN_LINES 16
`define EIEC_NUM_INT_LINES 7
`define EIEC_NUM_PINS 168
`define EIEC_PINS_PER_PORT 16
`define EIEC_SEL_WIDTH 4
`define EIEC_SEL_PER_REG 4
`define EIEC_NUM_SEL_REGS 4
`define EIEC_PIN_IDX_WIDTH 8

// APB register byte offsets.
`define EIEC_OFS_IRQ_MASK 8'h00
`define EIEC_OFS_EVT_MASK 8'h04
`define EIEC_OFS_RISE_SEL 8'h08
`define EIEC_OFS_FALL_SEL 8'h0c
`define EIEC_OFS_SW_TRIG 8'h10
`define EIEC_OFS_PENDING 8'h14
`define EIEC_OFS_PIN_SEL0 8'h18
`define EIEC_OFS_CTRL_STAT 8'h28
`define EIEC_OFS_CTRL_MASK 8'h2c

// Controller status bit positions.
`define EIEC_STAT_WIDTH 3
`define EIEC_STAT_LINE_REQ 0
`define EIEC_STAT_OVERRUN 1
`define EIEC_STAT_EVENT 2

// Reset values.
`define EIEC_RST_LINES 23'h000000
`define EIEC_RST_SEL 16'h0000
`define EIEC_RST_STAT 3'h0

`endif

/* hdl/eiec_pkg.sv */
package eiec_pkg;
  typedef logic [22:0] eiec_line_type;
  typedef logic [3:0] eiec_sel_type;
  typedef logic [15:0] eiec_selreg_type;
  typedef logic [2:0] eiec_stat_type;
  typedef logic [167:0] eiec_pins_type;
  typedef logic [15:0] eiec_pin_line_type;
endpackage : eiec_pkg

/* hdl/eiec_pin_mux.sv */
`include "eiec_cfg.svh"

module eiec_pin_mux (
  input wire eiec_pkg::eiec_pins_type gpio_pins,
  input wire logic [63:0] pin_sel,
  output logic [15:0] pin_lines
);
  import eiec_pkg::*;

  // Each external line picks the same-numbered pin of one port; a port
  // index beyond the last existing pin reads as a quiet low line.
  genvar g;
  generate
    for (g = 0; g < `EIEC_NUM_PIN_LINES; g++) begin : g_line
      wire eiec_sel_type sel;
      wire [`EIEC_PIN_IDX_WIDTH-1:0] idx;
      wire in_range;
      assign sel = pin_sel[g*`EIEC_SEL_WIDTH +: `EIEC_SEL_WIDTH];
      assign idx = {sel, 4'(g)};
      assign in_range = idx < 8'(`EIEC_NUM_PINS);
      assign pin_lines[g] = in_range ? gpio_pins[idx] : 1'b0;
    end
  endgenerate
endmodule : eiec_pin_mux

/* hdl/eiec_ctrl.sv */
// What this block does
// - Twenty-three edge detector lines raise requests.
// - Per-line rising, falling or both edge trigger.
// - Per-line mask blocks only that line's requests.
// - Software reads a per-line pending status.
// - Single-cycle input pulses still set pending.
// - GPIO pins multiplexed onto sixteen external lines.
`include "eiec_cfg.svh"

module eiec_ctrl (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire eiec_pkg::eiec_pins_type gpio_pins,
  input wire logic [6:0] internal_lines,
  output eiec_pkg::eiec_line_type irq_req,
  output eiec_pkg::eiec_line_type event_req,
  output logic ctrl_irq
);
  import eiec_pkg::*;

  // Configuration and state registers.
  eiec_line_type irq_mask;
  eiec_line_type evt_mask;
  eiec_line_type rise_sel;
  eiec_line_type fall_sel;
  eiec_line_type pending;
  eiec_line_type line_prev;
  logic prev_valid;
  eiec_selreg_type pin_sel [`EIEC_NUM_SEL_REGS];
  eiec_stat_type ctrl_stat;
  eiec_stat_type ctrl_mask;

  // Next values.
  eiec_line_type next_pending;
  eiec_stat_type next_ctrl_stat;
  eiec_line_type next_event_req;

  // Pin multiplexer and assembled line inputs.
  wire logic [63:0] pin_sel_flat;
  wire eiec_pin_line_type pin_lines;
  wire eiec_line_type line_in;

  assign pin_sel_flat = {pin_sel[3], pin_sel[2], pin_sel[1], pin_sel[0]};

  eiec_pin_mux u_pin_mux (
    .gpio_pins(gpio_pins),
    .pin_sel(pin_sel_flat),
    .pin_lines(pin_lines)
  );

  // Lines 0..15 come from the pins, lines 16..22 from on-chip sources.
  assign line_in = {internal_lines, pin_lines};

  // APB decode. The slave never inserts wait states.
  wire logic setup_ph;
  wire logic access_ph;
  wire logic wr_en;
  wire logic rd_done;
  wire logic hit_irq_mask;
  wire logic hit_evt_mask;
  wire logic hit_rise;
  wire logic hit_fall;
  wire logic hit_sw;
  wire logic hit_pend;
  wire logic hit_stat;
  wire logic hit_cmask;
  wire logic [3:0] hit_sel;
  wire logic addr_hit;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign hit_irq_mask = paddr == `EIEC_OFS_IRQ_MASK;
  assign hit_evt_mask = paddr == `EIEC_OFS_EVT_MASK;
  assign hit_rise = paddr == `EIEC_OFS_RISE_SEL;
  assign hit_fall = paddr == `EIEC_OFS_FALL_SEL;
  assign hit_sw = paddr == `EIEC_OFS_SW_TRIG;
  assign hit_pend = paddr == `EIEC_OFS_PENDING;
  assign hit_stat = paddr == `EIEC_OFS_CTRL_STAT;
  assign hit_cmask = paddr == `EIEC_OFS_CTRL_MASK;

  genvar s;
  generate
    for (s = 0; s < `EIEC_NUM_SEL_REGS; s++) begin : g_sel_hit
      assign hit_sel[s] = paddr == (`EIEC_OFS_PIN_SEL0 + 8'(4 * s));
    end
  endgenerate

  assign addr_hit = hit_irq_mask | hit_evt_mask | hit_rise | hit_fall |
                    hit_sw | hit_pend | hit_stat | hit_cmask | (|hit_sel);
  assign wr_en = access_ph & pwrite & addr_hit;
  assign rd_done = access_ph & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = access_ph & ~addr_hit;

  // Read multiplexer; captured in the setup cycle so prdata is a flop.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_irq_mask) begin
      rd_mux = {9'h000, irq_mask};
    end else if (hit_evt_mask) begin
      rd_mux = {9'h000, evt_mask};
    end else if (hit_rise) begin
      rd_mux = {9'h000, rise_sel};
    end else if (hit_fall) begin
      rd_mux = {9'h000, fall_sel};
    end else if (hit_pend) begin
      rd_mux = {9'h000, pending};
    end else if (hit_stat) begin
      rd_mux = {29'h0000_0000, ctrl_stat};
    end else if (hit_cmask) begin
      rd_mux = {29'h0000_0000, ctrl_mask};
    end else begin
      for (int k = 0; k < `EIEC_NUM_SEL_REGS; k++) begin
        if (hit_sel[k]) begin
          rd_mux = {16'h0000, pin_sel[k]};
        end
      end
    end
  end

  // Edge detection. The comparison uses the live input against the
  // previous sample, so a pulse seen high on only one edge is caught.
  // The first cycle after reset only loads the history, which avoids a
  // false edge from lines that are already high.
  wire eiec_line_type rise_edge;
  wire eiec_line_type fall_edge;
  wire eiec_line_type hw_trig;
  wire eiec_line_type sw_trig;
  wire eiec_line_type any_trig;
  wire eiec_line_type pend_set;
  wire eiec_line_type pend_clr;

  assign rise_edge = prev_valid ? (line_in & ~line_prev) : '0;
  assign fall_edge = prev_valid ? (~line_in & line_prev) : '0;
  assign hw_trig = (rise_edge & rise_sel) | (fall_edge & fall_sel);

  // A software trigger write acts as an edge on each written line, whatever edges are selected for it.
  assign sw_trig = (wr_en & hit_sw) ? pwdata[22:0] : '0;
  assign any_trig = hw_trig | sw_trig;

  // Only unmasked lines record a request; other lines are untouched.
  assign pend_set = any_trig & irq_mask;
  assign pend_clr = (wr_en & hit_pend) ? pwdata[22:0] : '0;

  // A new request in the clearing cycle survives the clear.
  assign next_pending = (pending & ~pend_clr) | pend_set;

  // Events are one-cycle pulses, gated by their own mask.
  assign next_event_req = any_trig & evt_mask;

  // Controller status: sticky, cleared by a completed read of it.
  wire eiec_stat_type stat_set;
  wire logic stat_rd_clr;

  assign stat_set[`EIEC_STAT_LINE_REQ] = |pend_set;
  assign stat_set[`EIEC_STAT_OVERRUN] = |(pend_set & pending);
  assign stat_set[`EIEC_STAT_EVENT] = |next_event_req;
  assign stat_rd_clr = rd_done & hit_stat;
  assign next_ctrl_stat = (stat_rd_clr ? '0 : ctrl_stat) | stat_set;

  // Requests toward the interrupt controller follow the pending flags.
  assign irq_req = pending & irq_mask;
  assign ctrl_irq = |(ctrl_stat & ctrl_mask);

  // Edge history.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      line_prev <= `EIEC_RST_LINES;
      prev_valid <= 1'b0;
    end else begin
      line_prev <= line_in;
      prev_valid <= 1'b1;
    end
  end

  // Pending flags, event pulses and controller status.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pending <= `EIEC_RST_LINES;
      event_req <= `EIEC_RST_LINES;
      ctrl_stat <= `EIEC_RST_STAT;
    end else begin
      pending <= next_pending;
      event_req <= next_event_req;
      ctrl_stat <= next_ctrl_stat;
    end
  end

  // Read data is taken in the setup cycle and held through the access.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // Mask and trigger selection registers.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_mask <= `EIEC_RST_LINES;
      evt_mask <= `EIEC_RST_LINES;
    end else if (wr_en) begin
      if (hit_irq_mask) begin
        irq_mask <= pwdata[22:0];
      end
      if (hit_evt_mask) begin
        evt_mask <= pwdata[22:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rise_sel <= `EIEC_RST_LINES;
      fall_sel <= `EIEC_RST_LINES;
    end else if (wr_en) begin
      if (hit_rise) begin
        rise_sel <= pwdata[22:0];
      end
      if (hit_fall) begin
        fall_sel <= pwdata[22:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_mask <= `EIEC_RST_STAT;
    end else if (wr_en && hit_cmask) begin
      ctrl_mask <= pwdata[2:0];
    end
  end

  // Pin selection registers, four lines of four bits each.
  generate
    for (s = 0; s < `EIEC_NUM_SEL_REGS; s++) begin : g_sel_reg
      always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
          pin_sel[s] <= `EIEC_RST_SEL;
        end else if (wr_en && hit_sel[s]) begin
          pin_sel[s] <= pwdata[15:0];
        end
      end
    end
  endgenerate

endmodule : eiec_ctrl

/* dv/eiec_ctrl_sva.sv */
module eiec_ctrl_sva (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire eiec_pkg::eiec_pins_type gpio_pins,
  input wire logic [6:0] internal_lines,
  input wire eiec_pkg::eiec_line_type irq_req,
  input wire eiec_pkg::eiec_line_type event_req,
  input wire logic ctrl_irq
);
  import eiec_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire acc;
  wire wr_pend;
  assign acc = psel && penable;
  assign wr_pend = acc && pwrite && paddr == 8'h14;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_ready_in_access: assert property (s_setup ##1 s_access |-> pready)
    else $error("pready low in access phase");
  a_unmapped_err: assert property (acc && paddr > 8'h2c |-> pslverr
    && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_err_only_access: assert property (pslverr |-> acc)
    else $error("pslverr outside access phase");
  a_pend_holds: assert property (!(acc && pwrite) |=>
    ($past(irq_req) & ~irq_req) == '0)
    else $error("pending dropped without a write");
  a_zero_wr_keeps: assert property (wr_pend && pwdata[22:0] == '0 |=>
    ($past(irq_req) & ~irq_req) == '0)
    else $error("writing zero changed pending");
  a_one_wr_clears: assert property (wr_pend && $stable(gpio_pins) &&
    $stable(internal_lines) |=> ({9'h0, irq_req} & $past(pwdata)) == '0)
    else $error("writing one did not clear pending");
  a_quiet_no_evt: assert property ($stable(gpio_pins) &&
    $stable(internal_lines) && !(acc && pwrite) |=> event_req == '0 &&
    (irq_req & ~$past(irq_req)) == '0)
    else $error("request without an input edge");
endmodule : eiec_ctrl_sva

bind eiec_ctrl eiec_ctrl_sva u_sva (.sys_clk(sys_clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .gpio_pins(gpio_pins), .internal_lines(internal_lines),
  .irq_req(irq_req), .event_req(event_req), .ctrl_irq(ctrl_irq));

/* dv/eiec_pins_model.sv */
module eiec_pins_model (
  input wire logic [3:0] port,
  input wire logic [15:0] lvl,
  output eiec_pkg::eiec_pins_type gpio_pins
);
  import eiec_pkg::*;
  // Unselected ports sit low, so a stale mux setting reads as zero.
  assign gpio_pins = eiec_pins_type'(lvl) << (port * 16);
endmodule : eiec_pins_model

/* dv/edge_interrupt_event_lines_test.sv */
module edge_interrupt_event_lines_test;
  timeunit 1ns;
  timeprecision 1ns;
  import eiec_pkg::*;
  `define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin \
    n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, seed = 32'h2a;
  logic pready, pslverr, ctrl_irq, err, anyq = 1'h0;
  logic [3:0] port = 4'h0;
  logic [15:0] lvl = 16'h0;
  logic [6:0] internal_lines = 7'h0;
  eiec_pins_type gpio_pins;
  eiec_line_type irq_req, event_req, t;
  eiec_line_type prev = 23'h0, rise = 23'h0, fall = 23'h0, imask = 23'h0;
  eiec_line_type emask = 23'h0, pend = 23'h0, evq = 23'h0;
  int n_mismatch = 0;
  int check_count = 0;

  eiec_pins_model u_pins (.port(port), .lvl(lvl), .gpio_pins(gpio_pins));
  eiec_ctrl uut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpio_pins(gpio_pins), .internal_lines(internal_lines),
    .irq_req(irq_req), .event_req(event_req), .ctrl_irq(ctrl_irq));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    // A transfer that has just ended still shows penable high here. Let
    // one edge pass so that psel is never assigned twice in one step.
    if (penable === 1'h1) begin
      @(posedge sys_clk);
    end
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      n_mismatch++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // Each value lasts one sample, so every edge is a one-cycle pulse.
  task automatic step(input eiec_line_type v);
    eiec_line_type e;
    lvl <= v[15:0];
    internal_lines <= v[22:16];
    e = (v & ~prev & rise) | (~v & prev & fall);
    prev = v;
    @(posedge sys_clk);
    `CHK("irq_req", pend & imask, irq_req)
    `CHK("event_req", evq, event_req)
    evq = e & emask;
    pend = pend | (e & imask);
    if ((e & imask) != 23'h0) anyq = 1'h1;
  endtask : step

  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'h1;
    @(posedge sys_clk);
    for (int a = 0; a < 12; a++) begin
      apb(1'h0, 8'(a * 4), 32'h0);
      `CHK("reset value", 32'h0, rd)
    end
    apb(1'h0, 8'h30, 32'h0);
    `CHK("unmapped err", 1'h1, err)
    $display("test reset done");
    for (int r = 0; r < 4; r++) begin
      step(23'h0);
      step(23'h0);
      // Lines are all low here, so moving the mux makes no edge.
      port <= 4'(r * 3);
      for (int s = 0; s < 4; s++) apb(1'h1, 8'(24 + s * 4), {8{4'(r * 3)}});
      rise = 23'(xs());
      fall = 23'(xs());
      imask = 23'(xs());
      emask = 23'(xs());
      apb(1'h1, 8'h08, {9'h0, rise});
      apb(1'h1, 8'h0c, {9'h0, fall});
      apb(1'h1, 8'h00, {9'h0, imask});
      apb(1'h1, 8'h04, {9'h0, emask});
      apb(1'h1, 8'h2c, {31'h0, r[0]});
      repeat (40) step(23'(xs()));
      step(prev);
      t = 23'(xs());
      apb(1'h1, 8'h10, {9'h0, t});
      evq = t & emask;
      pend = pend | (t & imask);
      if ((t & imask) != 23'h0) anyq = 1'h1;
      step(prev);
      apb(1'h0, 8'h14, 32'h0);
      `CHK("pending", {9'h0, pend}, rd)
      `CHK("ctrl_irq", anyq & r[0], ctrl_irq)
      apb(1'h0, 8'h28, 32'h0);
      `CHK("stat bit0", anyq, rd[0])
      anyq = 1'h0;
      apb(1'h1, 8'h14, 32'h0);
      t = 23'(xs());
      apb(1'h1, 8'h14, {9'h0, t});
      pend = pend & ~t;
      step(prev);
      apb(1'h0, 8'h14, 32'h0);
      `CHK("pending clr", {9'h0, pend}, rd)
      `CHK("ctrl_irq clr", 1'h0, ctrl_irq)
      $display("test round %0d done", r);
    end
    close_out();
  end
endmodule : edge_interrupt_event_lines_test
